// File: rtl/bms_pkg.sv
// Purpose: shared constants, types and crc step for the status readout
// Assumes: modbus rtu framing is delimited by the serial front end
// Notes:   addresses are frame addresses, one less than register numbers
package bms_pkg;

   // ***********************************************************
   // protocol constants
   // ***********************************************************
   localparam logic [7:0]  BMS_FUNC_READ   = 8'h03;
   localparam logic [7:0]  BMS_EXC_FLAG    = 8'h80;
   localparam logic [7:0]  BMS_EXC_FUNC    = 8'h01;
   localparam logic [7:0]  BMS_EXC_ADDR    = 8'h02;
   localparam logic [7:0]  BMS_EXC_VALUE   = 8'h03;
   localparam logic [7:0]  BMS_EXC_NONE    = 8'h00;
   localparam logic [7:0]  BMS_BCAST       = 8'h00;
   localparam logic [15:0] BMS_MAX_REGS    = 16'h007d;
   localparam logic [3:0]  BMS_REQ_BYTES   = 4'h8;
   localparam logic [15:0] BMS_CRC_INIT    = 16'hffff;
   localparam logic [15:0] BMS_CRC_POLY    = 16'ha001;
   localparam logic [15:0] BMS_CRC_GOOD    = 16'h0000;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [15:0] BMS_TABLE_ADDR  = 16'h2edf;
   localparam logic [15:0] BMS_STATUS_ADDR = 16'h2ee0;
   localparam int          BMS_TABLE_REGS  = 113;
   localparam logic [6:0]  BMS_IDX_VALID   = 7'h00;
   localparam logic [6:0]  BMS_IDX_STATUS  = 7'h01;
   localparam int          BMS_BIT_CLOSED  = 0;
   localparam int          BMS_BIT_TRIP    = 1;
   localparam int          BMS_BIT_FAULT   = 2;
   localparam logic [15:0] BMS_VALID_MASK  = 16'h0007;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef struct packed {
      logic [7:0]  slave;
      logic [7:0]  func;
      logic [15:0] start;
      logic [15:0] count;
      logic [15:0] crc;
   } bms_req_s;

   typedef struct packed {
      logic closed;
      logic trip;
      logic fault;
      logic motor;
   } bms_pins_s;

   typedef enum logic [7:0] {
      BMS_IDLE = 8'h01,
      BMS_ADDR = 8'h02,
      BMS_FUNC = 8'h04,
      BMS_BCNT = 8'h08,
      BMS_HI   = 8'h10,
      BMS_LO   = 8'h20,
      BMS_CRCL = 8'h40,
      BMS_CRCH = 8'h80
   } bms_tx_e;

   // one byte through the reflected modbus crc
   function automatic logic [15:0] bms_crc_step(input logic [15:0] crc,
                                                input logic [7:0]  data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ BMS_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// File: rtl/bms_crc16.sv
// Purpose: running modbus crc over a byte stream
// Assumes: clr and en may coincide; the byte then starts a fresh crc
// Notes:   crc_next shows the value after the current byte
`timescale 1ns/10ps
module bms_crc16
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc,
   output logic      [15:0] crc_next
);
   import bms_pkg::*;

   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic [15:0] base;

   // ***********************************************************
   // next value
   // ***********************************************************
   always_comb
   begin
      base    = clr ? BMS_CRC_INIT : crc_r;
      crc_nxt = en ? bms_crc_step(base, data) : base;
   end

   // register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         crc_r <= BMS_CRC_INIT;
      else
         crc_r <= crc_nxt;
   end

   assign crc      = crc_r;
   assign crc_next = crc_nxt;
endmodule

// File: rtl/bms_readout.sv
// Purpose: modbus read slave for the breaker common status table
// Assumes: bytes arrive framed; rx_end follows the last byte of a frame
// Notes:   contact pins are synchronised; table words past the first two come from update port
`timescale 1ns/10ps

module bms_readout
#(
   parameter int TABLE_REGS = bms_pkg::BMS_TABLE_REGS
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  slave_addr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_end,
   input  wire logic        open_closed_contact,
   input  wire logic        trip_indication,
   input  wire logic        fault_trip_indication,
   input  wire logic        motor_operator_fitted,
   input  wire logic        upd_valid,
   input  wire logic [6:0]  upd_index,
   input  wire logic [15:0] upd_data,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   output logic             tx_last,
   output logic             busy,
   output logic             crc_error
);
   import bms_pkg::*;

   // ***********************************************************
   // contact synchroniser
   // ***********************************************************
   bms_pins_s pin_s1_r, pin_s2_r, pin_s3_r, pin_r, pin_nxt;

   // a change counts once stages two and three agree
   always_comb
   begin
      pin_nxt = (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_r;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_r    <= '0;
      end
      else
      begin
         pin_s1_r <= {open_closed_contact, trip_indication,
                      fault_trip_indication, motor_operator_fitted};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_r    <= pin_nxt;
      end
   end

   // ***********************************************************
   // register table
   // ***********************************************************
   logic [15:0] table_mem [0:TABLE_REGS-1];
   logic [15:0] status_word;

   // status word from the settled contacts
   always_comb
   begin
      status_word                 = '0;
      status_word[BMS_BIT_CLOSED] = pin_r.closed;
      status_word[BMS_BIT_TRIP] = pin_r.trip & ~pin_r.motor;
      status_word[BMS_BIT_FAULT]  = pin_r.fault;
   end

   // measurement words refreshed by the trip unit
   always_ff @(posedge clk)
   begin
      if (upd_valid && (32'(upd_index) < TABLE_REGS))
         table_mem[upd_index] <= upd_data;
   end

   // word at a table index; first is the constant validity mask, second the live status word
   function automatic logic [15:0] word_at(input logic [6:0] i);
      if (i == BMS_IDX_VALID)
         return BMS_VALID_MASK;
      else if (i == BMS_IDX_STATUS)
         return status_word;
      else
         return table_mem[i];
   endfunction

   // ***********************************************************
   // request capture
   // ***********************************************************
   logic [7:0]  rx_buf_r [0:7];
   logic [3:0]  rx_cnt_r, rx_cnt_nxt;
   logic [15:0] rx_crc;
   logic        rx_take;
   bms_tx_e     st_r, st_nxt;

   assign rx_take = rx_valid && (st_r == BMS_IDLE);

   // byte counter saturates one past a full request
   always_comb
   begin
      rx_cnt_nxt = rx_cnt_r;
      if (rx_end)
         rx_cnt_nxt = '0;
      else if (rx_take && (rx_cnt_r <= BMS_REQ_BYTES))
         rx_cnt_nxt = rx_cnt_r + 4'h1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rx_cnt_r <= '0;
      else
         rx_cnt_r <= rx_cnt_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (rx_take && (rx_cnt_r < BMS_REQ_BYTES))
         rx_buf_r[rx_cnt_r[2:0]] <= rx_data;
   end

   bms_crc16 u_rx_crc
   (
      .clk      (clk),
      .rst      (rst),
      .clr      (rx_end),
      .en       (rx_take),
      .data     (rx_data),
      .crc      (rx_crc),
      .crc_next ()
   );

   // ***********************************************************
   // request decode
   // ***********************************************************
   bms_req_s    req;
   logic        crc_ok, addr_ok, req_go;
   logic [16:0] req_end, tbl_end;
   logic [7:0]  exc_code;

   always_comb
   begin
      req = {rx_buf_r[0], rx_buf_r[1], rx_buf_r[2], rx_buf_r[3],
             rx_buf_r[4], rx_buf_r[5], rx_buf_r[6], rx_buf_r[7]};
      crc_ok  = (rx_cnt_r == BMS_REQ_BYTES) && (rx_crc == BMS_CRC_GOOD);
      addr_ok = (req.slave == slave_addr) && (req.slave != BMS_BCAST);
      req_go  = rx_end && crc_ok && addr_ok;
      req_end = {1'b0, req.start} + {1'b0, req.count};
      tbl_end = {1'b0, BMS_TABLE_ADDR} + 17'(TABLE_REGS);
      if (req.func != BMS_FUNC_READ)
         exc_code = BMS_EXC_FUNC;
      else if ((req.count == '0) || (req.count > BMS_MAX_REGS))
         exc_code = BMS_EXC_VALUE;
      else if ((req.start < BMS_TABLE_ADDR) || (req_end > tbl_end))
         exc_code = BMS_EXC_ADDR;
      else
         exc_code = BMS_EXC_NONE;
   end

   // ***********************************************************
   // reply sequencer
   // ***********************************************************
   logic [7:0]  func_r, func_nxt, exc_r, exc_nxt;
   logic [6:0]  idx_r, idx_nxt, left_r, left_nxt;
   logic [7:0]  d_nxt;
   logic        v_nxt, last_nxt, adv, err_nxt;
   logic [15:0] tx_crc, tx_crc_next, cur_word, next_word;

   assign adv       = tx_valid && tx_ready;

   // words at the current and following index; re-read on any table change
   always_comb
   begin
      cur_word  = word_at(idx_r);
      next_word = word_at(idx_r + 7'h01);
   end

   // state, byte and counters of the reply
   always_comb
   begin
      st_nxt   = st_r;
      d_nxt    = tx_data;
      v_nxt    = tx_valid;
      last_nxt = tx_last;
      func_nxt = func_r;
      exc_nxt  = exc_r;
      idx_nxt  = idx_r;
      left_nxt = left_r;
      err_nxt  = rx_end && (rx_cnt_r != '0) && (rx_crc != BMS_CRC_GOOD);
      unique case (st_r)
         BMS_IDLE:
            if (req_go)
            begin
               st_nxt   = BMS_ADDR;
               d_nxt    = slave_addr;
               v_nxt    = 1'b1;
               func_nxt = req.func;
               exc_nxt  = exc_code;
               idx_nxt  = 7'(req.start - BMS_TABLE_ADDR);
               left_nxt = 7'(req.count);
            end
         BMS_ADDR:
            if (adv)
            begin
               st_nxt = BMS_FUNC;
               d_nxt  = (exc_r != BMS_EXC_NONE) ? (func_r | BMS_EXC_FLAG)
                                                : func_r;
            end
         BMS_FUNC:
            if (adv)
            begin
               st_nxt = BMS_BCNT;
               d_nxt  = (exc_r != BMS_EXC_NONE) ? exc_r
                                                : {left_r, 1'b0};
            end
         BMS_BCNT:
            if (adv)
            begin
               if (exc_r != BMS_EXC_NONE)
               begin
                  st_nxt = BMS_CRCL;
                  d_nxt  = tx_crc_next[7:0];
               end
               else
               begin
                  st_nxt = BMS_HI;
                  d_nxt  = cur_word[15:8];
               end
            end
         BMS_HI:
            if (adv)
            begin
               st_nxt = BMS_LO;
               d_nxt  = cur_word[7:0];
            end
         BMS_LO:
            if (adv)
            begin
               left_nxt = left_r - 7'h01;
               idx_nxt  = idx_r + 7'h01;
               if (left_r == 7'h01)
               begin
                  st_nxt = BMS_CRCL;
                  d_nxt  = tx_crc_next[7:0];
               end
               else
               begin
                  st_nxt = BMS_HI;
                  d_nxt  = next_word[15:8];
               end
            end
         BMS_CRCL:
            if (adv)
            begin
               st_nxt   = BMS_CRCH;
               d_nxt    = tx_crc[15:8];
               last_nxt = 1'b1;
            end
         BMS_CRCH:
            if (adv)
            begin
               st_nxt   = BMS_IDLE;
               v_nxt    = 1'b0;
               last_nxt = 1'b0;
            end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r      <= BMS_IDLE;
         tx_data   <= '0;
         tx_valid  <= 1'b0;
         tx_last   <= 1'b0;
         busy      <= 1'b0;
         crc_error <= 1'b0;
         func_r    <= '0;
         exc_r     <= '0;
         idx_r     <= '0;
         left_r    <= '0;
      end
      else
      begin
         st_r      <= st_nxt;
         tx_data   <= d_nxt;
         tx_valid  <= v_nxt;
         tx_last   <= last_nxt;
         busy      <= (st_nxt != BMS_IDLE);
         crc_error <= err_nxt;
         func_r    <= func_nxt;
         exc_r     <= exc_nxt;
         idx_r     <= idx_nxt;
         left_r    <= left_nxt;
      end
   end

   // crc over every reply byte before the crc itself
   bms_crc16 u_tx_crc
   (
      .clk      (clk),
      .rst      (rst),
      .clr      (st_r == BMS_IDLE),
      .en       (adv && (st_r != BMS_CRCL) && (st_r != BMS_CRCH)),
      .data     (tx_data),
      .crc      (tx_crc),
      .crc_next (tx_crc_next)
   );

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_func_echo: assert property ((st_r == BMS_FUNC) && (exc_r == '0)
      |-> tx_valid && (tx_data == BMS_FUNC_READ))
      else $error("function code not echoed");
   a_byte_count: assert property ((st_r == BMS_FUNC) && adv
      && (exc_r == '0) |=> (tx_data == {left_r, 1'b0}))
      else $error("byte count not twice the register count");
   a_open_closed: assert property ($changed(pin_r.closed)
      |-> status_word[BMS_BIT_CLOSED] == pin_r.closed)
      else $error("closed bit does not follow contact");
   a_trip_bit: assert property (pin_r.trip && !pin_r.motor
      |-> status_word[BMS_BIT_TRIP])
      else $error("trip bit missing");
   a_trip_forced: assert property (pin_r.motor
      |-> !status_word[BMS_BIT_TRIP])
      else $error("trip bit not forced low with motor operator");
   a_fault_flag: assert property (status_word[BMS_BIT_FAULT]
      == pin_r.fault)
      else $error("fault bit does not follow contact");
   a_valid_word: assert property (word_at(BMS_IDX_VALID)
      == BMS_VALID_MASK)
      else $error("validity word wrong");
   a_crc_drop: assert property (rx_end && (st_r == BMS_IDLE)
      && (rx_crc != BMS_CRC_GOOD) |=> !tx_valid ##1 !tx_valid)
      else $error("reply to frame with bad crc");
   a_full_table: assert property (req_go && (req.func == BMS_FUNC_READ)
      && (req.start == BMS_TABLE_ADDR) && (32'(req.count) == TABLE_REGS)
      && (st_r == BMS_IDLE) |=> (exc_r == '0) && (idx_r == '0))
      else $error("whole table read refused");
   a_hi_first: assert property ((st_r == BMS_HI) && adv
      |=> (st_r == BMS_LO) && (tx_data == cur_word[7:0]))
      else $error("low byte not after high byte");
endmodule

// File: sim/bms_master.sv
// Purpose: modbus master model facing the status readout
// Assumes: bytes are framed for the slave; rx_end marks line silence
// Notes:   slow mode drops tx_ready every other cycle, stalling each reply byte
`timescale 1ns/10ps
module bms_master
(
   input  wire logic       clk,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   input  wire logic       slow,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   output logic            rx_end,
   output logic            tx_ready
);
   logic [7:0]  rsp_q[$];
   logic [15:0] rsp_crc;
   logic [15:0] req_res;
   int          last_at;

   // reflected crc, init ffff, low byte sent first
   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
      end
      return r;
   endfunction

   initial
   begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_end   = 1'b0;
      tx_ready = 1'b1;
      rsp_crc  = 16'hffff;
      last_at  = 0;
      req_res  = 16'hffff;
   end

   // take reply bytes, running crc for the residue test
   always @(posedge clk)
   begin
      if (tx_valid === 1'b1 && tx_ready)
      begin
         rsp_q.push_back(tx_data);
         rsp_crc = crc_upd(rsp_crc, tx_data);
         if (tx_last)
            last_at = rsp_q.size();
      end
      #1 tx_ready = slow ? ~tx_ready : 1'b1;
   end

   // one read request, nb bytes of it, then end of frame
   task automatic send_req(input logic [7:0]  slv,
                           input logic [7:0]  fn,
                           input logic [15:0] st,
                           input logic [15:0] cnt,
                           input logic        bad,
                           input int          nb);
      logic [7:0]  b[8];
      logic [15:0] c;
      b = '{slv, fn, st[15:8], st[7:0], cnt[15:8], cnt[7:0], 8'h00, 8'h00};
      c = 16'hffff;
      for (int i = 0; i < 6; i++)
      begin
         c = crc_upd(c, b[i]);
      end
      b[6] = c[7:0] ^ {7'h00, bad};
      b[7] = c[15:8];
      rsp_q.delete();
      rsp_crc = 16'hffff;
      last_at = 0;
      req_res = 16'hffff;
      for (int i = 0; i < nb; i++)
      begin
         @(posedge clk);
         #1;
         rx_valid = 1'b1;
         rx_data  = b[i];
         req_res  = crc_upd(req_res, b[i]);
      end
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
      rx_end   = 1'b1;
      @(posedge clk);
      #1;
      rx_end   = 1'b0;
   endtask
endmodule

// File: sim/tb_breaker_status_modbus_readout.sv
// Purpose: self-checking bench for the breaker status readout
// Assumes: master model drives requests and accepts replies
// Notes:   table rows first, then frame faults and a mid-reply reset
`timescale 1ns/10ps
module tb_breaker_status_modbus_readout;
   import bms_pkg::*;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] start;
      logic [15:0] count;
      bms_pins_s   pins;
      logic        slow;
      logic [7:0]  code;
   } bms_row_s;

   logic        clk, rst, rx_valid, rx_end, tx_ready, slow;
   logic        tx_valid, tx_last, busy, crc_error, upd_valid;
   logic [7:0]  rx_data, tx_data, slave_addr;
   logic [6:0]  upd_index;
   logic [15:0] upd_data;
   bms_pins_s   pins;
   int          bad_count, num_checks, cycles;

   // ***********************************************************
   // ordinary cases: func, start, count, pins, slow, reply code
   // ***********************************************************
   bms_row_s rows [10] = '{
      '{8'h03, 16'h2edf, 16'h0071, 4'b1110, 1'b1, 8'h00},
      '{8'h03, 16'h2ee0, 16'h0001, 4'b1000, 1'b0, 8'h00},
      '{8'h03, 16'h2ee0, 16'h0001, 4'b0110, 1'b0, 8'h00},
      '{8'h03, 16'h2ee0, 16'h0001, 4'b0100, 1'b1, 8'h00},
      '{8'h03, 16'h2edf, 16'h0002, 4'b0101, 1'b1, 8'h00},
      '{8'h03, 16'h2eef, 16'h0002, 4'b0000, 1'b0, 8'h00},
      '{8'h04, 16'h2edf, 16'h0001, 4'b0000, 1'b0, 8'h01},
      '{8'h03, 16'h2ede, 16'h0001, 4'b0000, 1'b0, 8'h02},
      '{8'h03, 16'h2ee0, 16'h0071, 4'b0000, 1'b0, 8'h02},
      '{8'h03, 16'h2edf, 16'h0000, 4'b0000, 1'b0, 8'h03}
   };

   bms_readout u_dut
   (
      .clk                   (clk),
      .rst                   (rst),
      .slave_addr            (slave_addr),
      .rx_valid              (rx_valid),
      .rx_data               (rx_data),
      .rx_end                (rx_end),
      .open_closed_contact   (pins.closed),
      .trip_indication       (pins.trip),
      .fault_trip_indication (pins.fault),
      .motor_operator_fitted (pins.motor),
      .upd_valid             (upd_valid),
      .upd_index             (upd_index),
      .upd_data              (upd_data),
      .tx_ready              (tx_ready),
      .tx_valid              (tx_valid),
      .tx_data               (tx_data),
      .tx_last               (tx_last),
      .busy                  (busy),
      .crc_error             (crc_error)
   );

   bms_master u_mst
   (
      .clk      (clk),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .slow     (slow),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .rx_end   (rx_end),
      .tx_ready (tx_ready)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   function automatic logic [15:0] tbl_word(input int i);
      return 16'(i) * 16'h0101 ^ 16'h5a3c;
   endfunction

   // validity word, live status word, then table memory
   function automatic logic [15:0] word_at(input int i, input bms_pins_s p);
      if (i == 0)
         return 16'h0007;
      if (i == 1)
         return {13'h0000, p.fault, p.trip & ~p.motor, p.closed};
      return tbl_word(i);
   endfunction

   // one request and the reply compared byte by byte up to the crc, which is checked by residue
   task automatic run(input bms_row_s r, input logic [7:0] slv,
                      input logic bad, input int nb);
      logic [7:0]  e[$];
      logic [7:0]  code;
      logic [15:0] wd;
      logic        ans;
      int          n;
      ans = !bad && nb == 8 && slv == 8'h2f;
      pins = r.pins;
      slow = r.slow;
      u_mst.send_req(slv, r.func, r.start, r.count, bad, nb);
      check("reply start", {15'h0, tx_valid}, {15'h0, ans});
      check("crc flag", {15'h0, crc_error},
            {15'h0, nb > 0 && u_mst.req_res != 16'h0000});
      n = 0;
      while (busy !== 1'b0 && n < 4000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (3) @(posedge clk);
      #1;
      check("reply done", {15'h0, busy}, 16'h0000);
      code = r.code;
      if (ans)
         e.push_back(slv);
      if (ans && code == 8'h00)
      begin
         e.push_back(8'h03);
         e.push_back(8'(2 * r.count));
         for (int i = 0; i < r.count; i++)
         begin
            wd = word_at(int'(r.start) - 'h2edf + i, r.pins);
            e.push_back(wd[15:8]);
            e.push_back(wd[7:0]);
         end
      end
      else if (ans)
      begin
         e.push_back(r.func | 8'h80);
         e.push_back(code);
      end
      n = e.size() + (ans ? 2 : 0);
      check("reply length", 16'(u_mst.rsp_q.size()), 16'(n));
      for (int i = 0; i < e.size(); i++)
         check("reply byte", {8'h00, u_mst.rsp_q[i]}, {8'h00, e[i]});
      if (ans)
      begin
         check("reply crc", u_mst.rsp_crc, 16'h0000);
         check("last flag", 16'(u_mst.last_at), 16'(n));
      end
   endtask

   initial
   begin
      rst        = 1'b1;
      slave_addr = 8'h2f;
      pins       = 4'b0000;
      slow       = 1'b0;
      upd_valid  = 1'b0;
      upd_index  = 7'h00;
      upd_data   = 16'h0000;
      repeat (8) @(posedge clk);
      #1;
      check("busy in reset", {15'h0, busy}, 16'h0000);
      check("tx in reset", {15'h0, tx_valid}, 16'h0000);
      rst = 1'b0;
      // fill table memory, including the validity and status slots
      for (int i = 0; i < 113; i++)
      begin
         @(posedge clk);
         #1;
         upd_valid = 1'b1;
         upd_index = 7'(i);
         upd_data  = tbl_word(i);
      end
      @(posedge clk);
      #1;
      upd_valid = 1'b0;
      foreach (rows[i])
         run(rows[i], 8'h2f, 1'b0, 8);
      // ***********************************************************
      // frame faults, other slaves, short frame
      // ***********************************************************
      run(rows[1], 8'h2f, 1'b1, 8);
      run(rows[1], 8'h30, 1'b0, 8);
      run(rows[1], 8'h00, 1'b0, 8);
      run(rows[1], 8'h2f, 1'b0, 7);
      run(rows[2], 8'h2f, 1'b0, 8);
      // reset in the middle of a long reply
      slow = 1'b1;
      u_mst.send_req(8'h2f, 8'h03, 16'h2edf, 16'h0071, 1'b0, 8);
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b1;
      #1;
      check("busy after reset", {15'h0, busy}, 16'h0000);
      check("tx after reset", {15'h0, tx_valid}, 16'h0000);
      @(posedge clk);
      #1;
      rst = 1'b0;
      run(rows[4], 8'h2f, 1'b0, 8);
      give_verdict();
   end
endmodule
